// *** include/cic_pkg.sv ***
// package: constants and types of the central interrupt control block
package cic_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CIC_CTRL_ADDR = 8'he6;
  localparam logic [7:0] CIC_CTRL_RESET = 8'h87;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CIC_GLOBAL_TIMER_COUNT_ENABLE_BIT = 7;
  localparam int CIC_TLP_BIT = 6;
  localparam int CIC_TLS_BIT = 5;
  localparam int CIC_IEN_BIT = 4;
  localparam int CIC_IAM_BIT = 3;
  localparam int CIC_CPL_LSB = 0;
  localparam int CIC_CPL_W = 3;
  localparam logic [2:0] CIC_CPL_LOWEST = 3'h7;
  localparam int CIC_NEST_DEPTH = 8;
  localparam int CIC_TIMERS = 2;
  // ------------------------------------------------------------
  // cpu run state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CIC_RUN,
    CIC_WAIT,
    CIC_WAIT_DMA
  } cic_run_e;
endpackage

// *** rtl/cic_timer_gate.sv ***
// module: per-timer count enable gating with the global enable
`timescale 1ns/1ps
module cic_timer_gate
  import cic_pkg::*;
#(
  parameter int N = CIC_TIMERS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // enables
  input wire logic global_en,
  input wire logic [N-1:0] timer_ce,
  // gated result
  output logic [N-1:0] timer_count_en
);
  initial begin
    if (N < 1) begin
      $error("timer count must be at least one");
    end
  end

  typedef struct packed {
    logic [N-1:0] en;
  } cic_tg_s;

  cic_tg_s s_q;
  cic_tg_s s_d;

  // each timer counts only when both enables are set
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      s_d.en[i] = global_en & timer_ce[i]; // R3
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_count_en = s_q.en;
endmodule

// *** rtl/cic_level_stack.sv ***
// module: stack of saved priority levels for nested service
`timescale 1ns/1ps
module cic_level_stack
  import cic_pkg::*;
#(
  parameter int DEPTH = CIC_NEST_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // push and pop
  input wire logic push,
  input wire logic [2:0] push_level,
  input wire logic pop,
  // top of stack
  output logic [2:0] top_level,
  output logic empty
);
  localparam int PW = $clog2(DEPTH + 1);
  initial begin
    if (DEPTH < 1) begin
      $error("stack depth must be at least one");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][2:0] mem;
    logic [PW-1:0] cnt;
  } cic_ls_s;

  cic_ls_s s_q;
  cic_ls_s s_d;

  // push saves a level, pop drops it; full stack ignores push
  always_comb begin
    s_d = s_q;
    if (pop && s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - PW'(1);
    end else if (push && s_q.cnt != PW'(DEPTH)) begin
      s_d.mem[s_q.cnt] = push_level; // R14
      s_d.cnt = s_q.cnt + PW'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign empty = (s_q.cnt == '0);
  assign top_level = empty ? CIC_CPL_LOWEST : s_q.mem[s_q.cnt - PW'(1)];
endmodule

// *** rtl/cic_top.sv ***
// module: central interrupt control register and arbitration state
`timescale 1ns/1ps
// Function
// R1: reset loads the control register with 0x87.
// R2: control register sits at system register address 0xe6.
// R3: global timer enable ANDed with each timer enable.
// R4: top-level pending set by hardware on a top-level request.
// R5: software setting top-level pending acts like a real request.
// R6: select set needs accept enable and nest mask; clear needs mask only.
// R7: accept enable clear blocks all but the non-maskable interrupt; here a pending top-level request with select clear is also accepted.
// R8: concurrent mode clears accept enable on ack, sets it on return.
// R9: enable and disable instructions set and clear accept enable.
// R10: bit 3 selects concurrent (0) or nested (1) arbitration, software only.
// R11: bits 2..0 hold current level, 000 highest, 111 lowest.
// R12: requests are compared to the current level before acceptance.
// R13: current level written by hardware on service and by software.
// R14: preemption saves the previous level until return.
// R15: wait instruction halts execution until an enabled interrupt.
// R16: dma during wait is serviced, then the wait resumes.
// R17: acknowledging a top-level interrupt clears its pending bit.
module cic_top
  import cic_pkg::*;
#(
  parameter int TIMERS = CIC_TIMERS,
  parameter int DEPTH = CIC_NEST_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // instruction events
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic wait_for_interrupt_instr,
  // interrupt sources
  input wire logic top_level_req,
  input wire logic top_level_nest_mask,
  input wire logic nmi_req,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic dma_req,
  input wire logic dma_done,
  // timer gating
  input wire logic [TIMERS-1:0] timer_ce,
  output logic [TIMERS-1:0] timer_count_en,
  // cpu side
  output logic irq_ack,
  output logic top_level_ack,
  output logic nmi_ack,
  output logic cpu_halted,
  output logic dma_grant,
  output logic [7:0] central_irq_control
);
  initial begin
    if (DEPTH < 1 || TIMERS < 1) begin
      $error("depth and timer count must be at least one");
    end
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic global_timer_count_enable;
    logic tlp;
    logic tls;
    logic interrupt_accept_enable;
    logic arbitration_mode_select;
    logic [2:0] cpl;
    logic [7:0] rdata;
    logic hit;
    logic ack;
    logic tl_ack;
    logic nmi_ack;
    logic halted;
    logic dma_grant;
    cic_run_e run;
  } cic_s;

  cic_s s_q;
  cic_s s_d;

  logic stk_push;
  logic stk_pop;
  logic [2:0] stk_top;
  logic stk_empty;
  logic [2:0] push_level;
  logic [7:0] ctrl_now;

  // ------------------------------------------------------------
  // sub blocks
  // ------------------------------------------------------------
  cic_timer_gate #(
    .N(TIMERS)
  ) u_gate (
    .clk(clk),
    .rst_b(rst_b),
    .global_en(s_q.global_timer_count_enable), // R3
    .timer_ce(timer_ce),
    .timer_count_en(timer_count_en)
  );

  cic_level_stack #(
    .DEPTH(DEPTH)
  ) u_stack (
    .clk(clk),
    .rst_b(rst_b),
    .push(stk_push),
    .push_level(push_level),
    .pop(stk_pop),
    .top_level(stk_top),
    .empty(stk_empty)
  );

  // current register image
  assign ctrl_now = {s_q.global_timer_count_enable, s_q.tlp, s_q.tls, s_q.interrupt_accept_enable, s_q.arbitration_mode_select, s_q.cpl}; // R11

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic wr_hit;
  logic tl_ok;
  logic irq_ok;
  logic any_ok;

  always_comb begin
    s_d = s_q;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    push_level = s_q.cpl;
    wr_hit = reg_wr && (reg_addr == CIC_CTRL_ADDR); // R2
    s_d.ack = 1'b0;
    s_d.tl_ack = 1'b0;
    s_d.nmi_ack = 1'b0;
    s_d.hit = reg_rd && (reg_addr == CIC_CTRL_ADDR); // R2
    s_d.rdata = s_d.hit ? ctrl_now : 8'h00;

    // software writes take effect first; hardware events override
    if (wr_hit) begin
      s_d.global_timer_count_enable = reg_wdata[CIC_GLOBAL_TIMER_COUNT_ENABLE_BIT];
      s_d.tlp = reg_wdata[CIC_TLP_BIT]; // R5
      s_d.tls = reg_wdata[CIC_TLS_BIT];
      s_d.interrupt_accept_enable = reg_wdata[CIC_IEN_BIT];
      s_d.arbitration_mode_select = reg_wdata[CIC_IAM_BIT]; // R10
      s_d.cpl = reg_wdata[CIC_CPL_LSB +: CIC_CPL_W]; // R13
    end
    if (enable_interrupts_instr) begin
      s_d.interrupt_accept_enable = 1'b1; // R9
    end
    if (disable_interrupts_instr) begin
      s_d.interrupt_accept_enable = 1'b0; // R9
    end

    // return restores the saved level and re-enables in concurrent mode
    if (return_from_interrupt_instr) begin
      if (!s_q.arbitration_mode_select) begin
        s_d.interrupt_accept_enable = 1'b1; // R8
      end
      s_d.cpl = stk_top; // R14
      stk_pop = 1'b1;
    end

    // hardware top-level request sets pending; set beats a clearing write
    if (top_level_req) begin
      s_d.tlp = 1'b1; // R4
    end

    // acceptance checks
    tl_ok = s_q.tlp && top_level_nest_mask && (!s_q.tls || s_q.interrupt_accept_enable); // R6
    irq_ok = irq_req && s_q.interrupt_accept_enable && (irq_level < s_q.cpl); // R7 R12
    any_ok = 1'b0;

    if (nmi_req) begin
      s_d.nmi_ack = 1'b1; // R7
      any_ok = 1'b1;
    end else if (tl_ok && !return_from_interrupt_instr) begin
      s_d.tl_ack = 1'b1;
      // a same-cycle hardware or software set beats the clear
      s_d.tlp = top_level_req || (wr_hit && reg_wdata[CIC_TLP_BIT]); // R17
      any_ok = 1'b1;
    end else if (irq_ok && !return_from_interrupt_instr) begin
      s_d.ack = 1'b1;
      stk_push = 1'b1; // R14
      push_level = s_q.cpl;
      s_d.cpl = irq_level; // R13
      if (!s_q.arbitration_mode_select) begin
        s_d.interrupt_accept_enable = 1'b0; // R8
      end
      any_ok = 1'b1;
    end

    // run state: wait, dma inside wait
    case (s_q.run)
      CIC_RUN: begin
        if (wait_for_interrupt_instr && !any_ok) begin
          s_d.run = CIC_WAIT; // R15
        end
      end
      CIC_WAIT: begin
        if (any_ok) begin
          s_d.run = CIC_RUN; // R15
        end else if (dma_req) begin
          s_d.run = CIC_WAIT_DMA; // R16
        end
      end
      CIC_WAIT_DMA: begin
        if (dma_done) begin
          s_d.run = CIC_WAIT; // R16
        end
      end
      default: begin
        s_d.run = CIC_RUN;
      end
    endcase
    s_d.halted = (s_d.run == CIC_WAIT);
    s_d.dma_grant = (s_d.run == CIC_WAIT_DMA);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.global_timer_count_enable <= CIC_CTRL_RESET[CIC_GLOBAL_TIMER_COUNT_ENABLE_BIT]; // R1
      s_q.tlp <= CIC_CTRL_RESET[CIC_TLP_BIT];
      s_q.tls <= CIC_CTRL_RESET[CIC_TLS_BIT];
      s_q.interrupt_accept_enable <= CIC_CTRL_RESET[CIC_IEN_BIT];
      s_q.arbitration_mode_select <= CIC_CTRL_RESET[CIC_IAM_BIT];
      s_q.cpl <= CIC_CTRL_RESET[CIC_CPL_LSB +: CIC_CPL_W]; // R1
      s_q.run <= CIC_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = s_q.rdata;
  assign reg_hit = s_q.hit;
  assign irq_ack = s_q.ack;
  assign top_level_ack = s_q.tl_ack;
  assign nmi_ack = s_q.nmi_ack;
  assign cpu_halted = s_q.halted;
  assign dma_grant = s_q.dma_grant;
  assign central_irq_control = ctrl_now;
endmodule

// *** verification/cic_top_properties.sv ***
// checker: port-level properties of the central interrupt control block
`timescale 1ns/1ps
module cic_top_properties
  import cic_pkg::*;
#(
  parameter int TIMERS = CIC_TIMERS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // events and sources
  input wire logic return_from_interrupt_instr,
  input wire logic wait_for_interrupt_instr,
  input wire logic top_level_req,
  input wire logic top_level_nest_mask,
  input wire logic nmi_req,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic dma_req,
  input wire logic [TIMERS-1:0] timer_ce,
  // outputs
  input wire logic [TIMERS-1:0] timer_count_en,
  input wire logic irq_ack,
  input wire logic top_level_ack,
  input wire logic cpu_halted,
  input wire logic [7:0] central_irq_control
);
  logic [7:0] cr;
  // short name for the register image
  assign cr = central_irq_control;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // maskable request that passes enable and level compare
  sequence irq_ok;
    irq_req && cr[4] && irq_level < cr[2:0] && !cr[6] && !nmi_req && !return_from_interrupt_instr;
  endsequence
  // pending top-level request let through by select, enable and mask
  sequence tl_ok;
    cr[6] && top_level_nest_mask && (!cr[5] || cr[4]) && !nmi_req && !return_from_interrupt_instr;
  endsequence
  reset_image_a: assert property ($rose(rst_b) |-> cr == CIC_CTRL_RESET)
    else $error("image not at reset value");
  timer_gate_a: assert property (1 |=> timer_count_en == ($past(cr[7]) ? $past(timer_ce) : '0))
    else $error("timer enable not gated");
  irq_accept_a: assert property (irq_ok |=> irq_ack && cr[2:0] == $past(irq_level)
    && cr[4] == $past(cr[3])) else $error("request not taken");
  irq_refuse_a: assert property (irq_req && (!cr[4] || irq_level >= cr[2:0]) |=> !irq_ack)
    else $error("request taken wrongly");
  tl_accept_a: assert property (tl_ok |=> top_level_ack && (!cr[6] || $past(top_level_req)))
    else $error("top-level not taken");
  tl_refuse_a: assert property (cr[6] && !(top_level_nest_mask && (!cr[5] || cr[4]))
    |=> !top_level_ack) else $error("top-level taken wrongly");
  tl_pending_a: assert property (top_level_req |=> cr[6])
    else $error("pending not set");
  wait_halt_a: assert property (wait_for_interrupt_instr && !irq_req && !cr[6] && !dma_req
    && !nmi_req |=> cpu_halted) else $error("wait not entered");
endmodule
bind cic_top cic_top_properties #(.TIMERS(TIMERS)) chk_u (.clk, .rst_b,
  .return_from_interrupt_instr, .wait_for_interrupt_instr, .top_level_req, .top_level_nest_mask,
  .nmi_req, .irq_req, .irq_level, .dma_req, .timer_ce, .timer_count_en, .irq_ack, .top_level_ack,
  .cpu_halted, .central_irq_control);

// *** verification/cic_source_model.sv ***
// model: interrupt and dma sources beside the block
`timescale 1ns/1ps
module cic_source_model #(
  parameter int LAT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench commands
  input wire logic raise_irq,
  input wire logic [2:0] level,
  input wire logic raise_dma,
  // block side
  input wire logic irq_ack,
  input wire logic dma_grant,
  output logic irq_req,
  output logic [2:0] irq_level,
  output logic dma_req,
  output logic dma_done
);
  int n;
  int m;
  // request held until taken or given up; dma ends after LAT grant cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      irq_level <= 3'h0;
      dma_req <= 1'b0;
      dma_done <= 1'b0;
      n <= 0;
      m <= 0;
    end else begin
      dma_done <= 1'b0;
      n <= irq_req ? n + 1 : 0;
      m <= (dma_grant && dma_req) ? m + 1 : 0;
      if (raise_irq) begin
        irq_req <= 1'b1;
        irq_level <= level;
      end else if (irq_ack || n == 4) begin
        irq_req <= 1'b0;
        irq_level <= ~irq_level; // released lines do not keep the level
      end
      if (raise_dma) begin
        dma_req <= 1'b1;
      end else if (m == LAT) begin
        dma_req <= 1'b0;
        dma_done <= 1'b1;
      end
    end
  end
endmodule

// *** verification/testbench.sv ***
// testbench: directed scenarios for the central interrupt control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import cic_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] ins = 4'h0;
  logic tl_req = 1'b0;
  logic mask = 1'b0;
  logic raise = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic dma = 1'b0;
  logic nmi = 1'b0;
  logic nmi_ack_w;
  logic [1:0] tce = 2'h3;
  logic irq_req, dma_req, dma_done, irq_ack, tl_ack, halted, grant, hit;
  logic [2:0] irq_level;
  logic [1:0] tcen;
  logic [7:0] rdata, img;
  int fail_count = 0;
  int tests_run = 0;
  int a, t;
  // 20 MHz core clock
  always #25 clk = ~clk;
  cic_top dut_u (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(rdata),
    .reg_hit(hit), .enable_interrupts_instr(ins[0]), .disable_interrupts_instr(ins[1]),
    .return_from_interrupt_instr(ins[2]), .wait_for_interrupt_instr(ins[3]),
    .top_level_req(tl_req), .top_level_nest_mask(mask), .nmi_req(nmi), .irq_req, .irq_level,
    .dma_req, .dma_done, .timer_ce(tce), .timer_count_en(tcen), .irq_ack,
    .top_level_ack(tl_ack), .nmi_ack(nmi_ack_w), .cpu_halted(halted), .dma_grant(grant),
    .central_irq_control(img));
  cic_source_model src_u (.clk, .rst_b, .raise_irq(raise), .level(lvl), .raise_dma(dma),
    .irq_ack, .dma_grant(grant), .irq_req, .irq_level, .dma_req, .dma_done);
  // verdict and end of run
  task results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one-cycle strobes: register write, read, instruction
  task wr(input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, CIC_CTRL_ADDR, d};
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] ad);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task pulse(input logic [3:0] v);
    @(posedge clk);
    ins <= v;
    @(posedge clk);
    ins <= 4'h0;
    #1;
  endtask
  // count acknowledges over six cycles
  task watch();
    a = 0;
    t = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      a += int'(irq_ack === 1'b1);
      t += int'(tl_ack === 1'b1);
    end
  endtask
  task irq(input logic [2:0] l);
    @(posedge clk);
    {raise, lvl} <= {1'b1, l};
    @(posedge clk);
    raise <= 1'b0;
    watch();
  endtask
  // bounded wait for halted (w=1) or dma grant (w=0)
  task until_hi(input logic w);
    int k;
    for (k = 0; k < 12; k++) begin
      if ((w ? halted : grant) === 1'b1) break;
      @(posedge clk);
      #1;
    end
    if (k == 12) begin
      fail_count++;
      results();
    end
  endtask
  task t_regs();
    `CHK("image", 8'h87, img)
    `CHK("timers", 2'h3, tcen)
    @(posedge clk);
    tce <= 2'h2;
    @(posedge clk);
    #1;
    `CHK("timer one", 2'h2, tcen)
    wr(8'h07);
    rd(CIC_CTRL_ADDR);
    `CHK("timers off", 2'h0, tcen)
    `CHK("read", 9'h107, {hit, rdata})
    rd(8'he5);
    `CHK("stray read", 9'h000, {hit, rdata})
    $display("test regs done");
  endtask
  task t_conc();
    wr(8'h97);
    pulse(4'h2);
    `CHK("di", 1'b0, img[4])
    pulse(4'h1);
    `CHK("ei", 1'b1, img[4])
    irq(3'h2);
    `CHK("taken", 9'h182, {a[0], img})
    irq(3'h1);
    `CHK("masked", 0, a)
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    #1;
    `CHK("nmi", 2'h2, {nmi_ack_w, img[4]})
    pulse(4'h4);
    `CHK("return", 8'h97, img)
    $display("test concurrent done");
  endtask
  task t_nest();
    wr(8'h9f);
    irq(3'h5);
    `CHK("level five", 8'h9d, img)
    irq(3'h2);
    `CHK("preempt", 8'h9a, img)
    irq(3'h3);
    `CHK("lower held", 0, a)
    pulse(4'h4);
    `CHK("restore", 8'h9d, img)
    pulse(4'h4);
    `CHK("restore two", 8'h9f, img)
    $display("test nested done");
  endtask
  task t_top();
    @(posedge clk);
    mask <= 1'b1;
    wr(8'hdf);
    watch();
    `CHK("soft request", 2'h2, {t[0], img[6]})
    wr(8'he7);
    watch();
    `CHK("select blocks", 0, t)
    pulse(4'h1);
    watch();
    `CHK("select passes", 2'h2, {t[0], img[6]})
    @(posedge clk);
    {mask, tl_req} <= 2'h1;
    @(posedge clk);
    tl_req <= 1'b0;
    watch();
    `CHK("hw pending", 2'h1, {t[0], img[6]})
    wr(8'h9f);
    $display("test top level done");
  endtask
  task t_wait();
    pulse(4'h8);
    `CHK("halted", 1'b1, halted)
    @(posedge clk);
    dma <= 1'b1;
    @(posedge clk);
    dma <= 1'b0;
    until_hi(1'b0);
    `CHK("dma in wait", 2'h1, {halted, grant})
    until_hi(1'b1);
    `CHK("back to wait", 1'b1, halted)
    irq(3'h1);
    `CHK("woken", 2'h2, {a[0], halted})
    $display("test wait done");
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_regs();
    t_conc();
    t_nest();
    t_top();
    t_wait();
    results();
  end
endmodule
